// ===== logic/ldcd_pkg.sv
/*
 Shared constants for the logical device configuration bank and I/O decode.
 Assumes an index/data configuration port already decoded by the host bus front end.
*/
package ldcd_pkg;
	localparam int          LDCD_NUM_DEV       = 12;
	localparam logic [7:0]  LDCD_IDX_LDN       = 8'h07;
	localparam logic [7:0]  LDCD_IDX_ACTIVATE  = 8'h30;
	localparam logic [7:0]  LDCD_IDX_RSV_LO    = 8'h31;
	localparam logic [7:0]  LDCD_IDX_RSV_HI    = 8'h5f;
	localparam logic [7:0]  LDCD_IDX_BASE_HIGH = 8'h60;
	localparam logic [7:0]  LDCD_IDX_BASE_LOW  = 8'h61;
	localparam logic [7:0]  LDCD_IDX_BASE2_HIGH = 8'h62;
	localparam logic [7:0]  LDCD_IDX_BASE2_LOW = 8'h63;
	localparam logic [7:0]  LDCD_IDX_IRQ_PRI   = 8'h70;
	localparam logic [7:0]  LDCD_IDX_IRQ_RSV_A = 8'h71;
	localparam logic [7:0]  LDCD_IDX_IRQ_SEC   = 8'h72;
	localparam logic [7:0]  LDCD_IDX_IRQ_RSV_B = 8'h73;
	localparam logic [7:0]  LDCD_IDX_DMA       = 8'h74;
	localparam logic [7:0]  LDCD_IDX_DMA_RSV   = 8'h75;
	localparam logic [7:0]  LDCD_IDX_VENDOR_LO = 8'he0;
	localparam logic [7:0]  LDCD_IDX_LAST      = 8'hff;
	localparam logic [3:0]  LDCD_LDN_FLOPPY    = 4'h0;
	localparam logic [3:0]  LDCD_LDN_PARALLEL  = 4'h3;
	localparam logic [3:0]  LDCD_LDN_SERIAL1   = 4'h4;
	localparam logic [3:0]  LDCD_LDN_SERIAL2   = 4'h5;
	localparam logic [3:0]  LDCD_LDN_KEYBOARD  = 4'h7;
	localparam logic [3:0]  LDCD_LDN_GAME      = 4'h9;
	localparam logic [3:0]  LDCD_LDN_RUNTIME   = 4'ha;
	localparam logic [3:0]  LDCD_LDN_MIDI      = 4'hb;
	localparam logic [7:0]  LDCD_RST_ZERO      = 8'h00;
	localparam logic [7:0]  LDCD_RST_IRQ_FLOPPY = 8'h06;
	localparam logic [7:0]  LDCD_RST_DMA_FLOPPY = 8'h02;
	localparam logic [7:0]  LDCD_RST_DMA_OTHER = 8'h04;
	localparam logic [11:0] LDCD_BASE_MIN      = 12'h100;
	localparam logic [11:0] LDCD_BASE_MAX8     = 12'hff8;
	localparam logic [11:0] LDCD_BASE_MAX4     = 12'hffc;
	localparam logic [11:0] LDCD_BASE_MAX1     = 12'hfff;
	localparam logic [11:0] LDCD_BASE_MAX2     = 12'hffe;
	localparam logic [11:0] LDCD_RT_MAX        = 12'hf7f;
	localparam logic [11:0] LDCD_ECP_OFFSET    = 12'h400;
	localparam logic [11:0] LDCD_ECP_SPAN      = 12'h003;
	localparam logic [11:0] LDCD_SPAN8         = 12'h008;
	localparam logic [11:0] LDCD_SPAN4         = 12'h004;
	localparam logic [11:0] LDCD_SPAN2         = 12'h002;
	localparam logic [11:0] LDCD_SPAN1         = 12'h001;
	localparam logic [11:0] LDCD_RT_SPAN       = 12'h080;
	localparam logic [11:0] LDCD_KBD_DATA      = 12'h060;
	localparam logic [11:0] LDCD_KBD_CMD       = 12'h064;
	localparam logic        LDCD_IRQ_EDGE_HIGH = 1'b1;
endpackage

// ===== logic/ldcd_dec_if.sv
/*
 Carrier between the bank and the address decoder.
 Assumes both ends run on the same clock.
*/
interface ldcd_dec_if;
	import ldcd_pkg::*;
	logic [15:0] base  [LDCD_NUM_DEV];
	logic        active[LDCD_NUM_DEV];
	logic        qual16;
	logic [15:0] addr;
	logic        cycle;
	logic [LDCD_NUM_DEV-1:0] hit;
	logic        ecp_hit;
	logic        epp_ok;
	logic [LDCD_NUM_DEV-1:0] base_ok;
	modport bank (output base, active, qual16, addr, cycle, input hit, ecp_hit, epp_ok, base_ok);
	modport dec  (input base, active, qual16, addr, cycle, output hit, ecp_hit, epp_ok, base_ok);
endinterface

// ===== logic/ldcd_addr_decode.sv
/*
 Combinational base address check and I/O cycle claim for each logical device.
 Assumes bank values are registered; results are registered by the bank.
*/
module ldcd_addr_decode
	import ldcd_pkg::*;
(
	// Bank side
	ldcd_dec_if.dec d
);
	function automatic logic in_span(input logic [11:0] a, input logic [11:0] b, input logic [11:0] span);
		logic [12:0] lim;
		lim = {1'b0, b} + {1'b0, span};
		in_span = ({1'b0, a} >= {1'b0, b}) && ({1'b0, a} < lim);
	endfunction

	logic [11:0] a;
	logic        up_ok;
	assign a     = d.addr[11:0];
	assign up_ok = !d.qual16 || (d.addr[15:12] == 4'h0);

	always_comb
	begin
		d.base_ok = '0;
		d.hit     = '0;
		d.ecp_hit = 1'b0;
		d.epp_ok  = 1'b0;
		for (int i = 0; i < LDCD_NUM_DEV; i++)
		begin
			logic [11:0] b;
			logic [11:0] span;
			logic        ok;
			b    = d.base[i][11:0];
			span = LDCD_SPAN8;
			ok   = 1'b0;
			case (4'(i))
				LDCD_LDN_FLOPPY, LDCD_LDN_SERIAL1, LDCD_LDN_SERIAL2:
					ok = b >= LDCD_BASE_MIN && b <= LDCD_BASE_MAX8 && b[2:0] == 3'h0;
				LDCD_LDN_PARALLEL:
				begin
					ok   = b >= LDCD_BASE_MIN && b <= LDCD_BASE_MAX4 && b[1:0] == 2'h0;
					span = (b[2] == 1'b0) ? LDCD_SPAN8 : LDCD_SPAN4;
				end
				LDCD_LDN_KEYBOARD:
					ok = 1'b1;
				LDCD_LDN_GAME:
				begin
					ok   = b >= LDCD_BASE_MIN && b <= LDCD_BASE_MAX1;
					span = LDCD_SPAN1;
				end
				LDCD_LDN_RUNTIME:
				begin
					ok   = b <= LDCD_RT_MAX && b[6:0] == 7'h00;
					span = LDCD_RT_SPAN;
				end
				LDCD_LDN_MIDI:
				begin
					ok   = b >= LDCD_BASE_MIN && b <= LDCD_BASE_MAX2 && b[0] == 1'b0;
					span = LDCD_SPAN2;
				end
				default:
					ok = 1'b0;
			endcase
			d.base_ok[i] = ok;
			if (d.cycle && up_ok && ok && d.active[i])
			begin
				if (4'(i) == LDCD_LDN_KEYBOARD)
					d.hit[i] = (a == LDCD_KBD_DATA) || (a == LDCD_KBD_CMD);
				else
					d.hit[i] = in_span(a, b, span);
				if (4'(i) == LDCD_LDN_PARALLEL)
				begin
					d.ecp_hit = in_span(a, 12'(b + LDCD_ECP_OFFSET), LDCD_ECP_SPAN);
					d.hit[i]  = d.hit[i] || d.ecp_hit;
					d.epp_ok  = (b[2] == 1'b0);
				end
			end
		end
	end
endmodule

// ===== logic/ldcd_bank.sv
/*
 Logical device configuration register bank with its I/O decode claim.
 Assumes the host bus front end presents decoded index/data port accesses as
 one-cycle strobes on clk_sys, and a configuration-state level from the global block.
*/
module ldcd_bank
	import ldcd_pkg::*;
#(
	parameter int NUM_DEV = LDCD_NUM_DEV
)
(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// Configuration port
	input  wire logic        cfg_mode,
	input  wire logic        idx_wr,
	input  wire logic        data_wr,
	input  wire logic        data_rd,
	input  wire logic [7:0]  wdata,
	output logic [7:0]       rdata,
	output logic [7:0]       index,
	// Power control from each device, and the upper address qualifier
	input  wire logic [11:0] pwr_set,
	input  wire logic [11:0] pwr_clr,
	input  wire logic        qual16,
	// Host I/O cycle
	input  wire logic        io_cycle,
	input  wire logic [15:0] io_addr,
	output logic [11:0]      io_hit,
	output logic             ecp_hit,
	output logic             epp_ok,
	// Per-device state
	output logic [11:0]      dev_on,
	output logic [11:0]      base_valid,
	output logic             irq_edge_high
);
	// Device map and port widths are fixed, so refuse any other device count at elaboration
	if (NUM_DEV != LDCD_NUM_DEV)
	begin : g_bad_num_dev
		$error("NUM_DEV must equal the number of logical devices");
	end

	typedef enum {LDCD_ST_IDLE, LDCD_ST_CONFIG} ldcd_state_t;

	ldcd_state_t  state_reg;
	logic [7:0]   index_reg;
	logic [3:0]   ldn_reg;
	logic [11:0]  act_reg;
	logic [7:0]   base_hi_reg  [LDCD_NUM_DEV];
	logic [7:0]   base_lo_reg  [LDCD_NUM_DEV];
	logic [7:0]   base2_hi_reg [LDCD_NUM_DEV];
	logic [7:0]   base2_lo_reg [LDCD_NUM_DEV];
	logic [7:0]   irq_reg      [LDCD_NUM_DEV];
	logic [7:0]   irq2_reg;
	logic [7:0]   dma_reg      [LDCD_NUM_DEV];
	logic [7:0]   rdata_reg;
	logic [7:0]   rdata_next;
	logic [11:0]  hit_reg;
	logic         ecp_reg;
	logic         epp_reg;
	logic [11:0]  valid_reg;
	logic         cfg_ok;
	logic         cfg_wr;
	logic [11:0]  act_next;

	ldcd_dec_if dec_bus ();

	// Base register usage per device
	function automatic logic uses_base(input logic [3:0] ldn);
		case (ldn)
			LDCD_LDN_FLOPPY, LDCD_LDN_PARALLEL, LDCD_LDN_SERIAL1, LDCD_LDN_SERIAL2,
			LDCD_LDN_GAME, LDCD_LDN_RUNTIME, LDCD_LDN_MIDI:
				uses_base = 1'b1;
			default:
				uses_base = 1'b0;
		endcase
	endfunction

	function automatic logic uses_base2(input logic [3:0] ldn);
		uses_base2 = 1'b0;
	endfunction

	function automatic logic uses_dma(input logic [3:0] ldn);
		uses_dma = (ldn == LDCD_LDN_FLOPPY) || (ldn == LDCD_LDN_PARALLEL);
	endfunction

	function automatic logic [7:0] irq_default(input logic [3:0] ldn);
		irq_default = (ldn == LDCD_LDN_FLOPPY) ? LDCD_RST_IRQ_FLOPPY : LDCD_RST_ZERO;
	endfunction

	function automatic logic [7:0] dma_default(input logic [3:0] ldn);
		dma_default = (ldn == LDCD_LDN_FLOPPY) ? LDCD_RST_DMA_FLOPPY : LDCD_RST_DMA_OTHER;
	endfunction

	function automatic logic ldn_exists(input logic [3:0] ldn);
		ldn_exists = ldn < 4'(LDCD_NUM_DEV);
	endfunction

	// Configuration state tracking
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			state_reg <= LDCD_ST_IDLE;
		else
		begin
			case (state_reg)
				LDCD_ST_IDLE:
					if (cfg_mode)
						state_reg <= LDCD_ST_CONFIG;
				LDCD_ST_CONFIG:
					if (!cfg_mode)
						state_reg <= LDCD_ST_IDLE;
				default:
					state_reg <= LDCD_ST_IDLE;
			endcase
		end
	end

	// Bank access needs the level now and the state flop from the cycle before
	assign cfg_ok = cfg_mode && (state_reg == LDCD_ST_CONFIG);
	assign cfg_wr = data_wr && cfg_ok;

	// Index latch follows the configuration level alone
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			index_reg <= LDCD_RST_ZERO;
		else if (idx_wr && cfg_mode)
			index_reg <= wdata;
	end

	// Logical device number picks the bank that the upper indices address
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			ldn_reg <= 4'h0;
		else if (cfg_wr && index_reg == LDCD_IDX_LDN)
			ldn_reg <= wdata[3:0];
	end

	// Activate bit and power control bit share one flop, so they cannot disagree
	always_comb
	begin
		act_next = act_reg;
		for (int i = 0; i < LDCD_NUM_DEV; i++)
		begin
			if (pwr_clr[i])
				act_next[i] = 1'b0;
			if (pwr_set[i])
				act_next[i] = 1'b1;
		end
		if (cfg_wr && index_reg == LDCD_IDX_ACTIVATE && ldn_exists(ldn_reg))
			act_next[ldn_reg] = wdata[0];
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			act_reg <= '0;
		else
			act_reg <= act_next;
	end

	// Per-device registers
	generate
		for (genvar g = 0; g < LDCD_NUM_DEV; g++)
		begin : g_dev
			localparam logic [3:0] LDN = 4'(g);
			logic sel;
			assign sel = cfg_wr && (ldn_reg == LDN);

			always_ff @(posedge clk_sys)
			begin
				if (rst)
				begin
					base_hi_reg[g]  <= LDCD_RST_ZERO;
					base_lo_reg[g]  <= LDCD_RST_ZERO;
					base2_hi_reg[g] <= LDCD_RST_ZERO;
					base2_lo_reg[g] <= LDCD_RST_ZERO;
				end
				else if (sel)
				begin
					if (index_reg == LDCD_IDX_BASE_HIGH && uses_base(LDN))
						base_hi_reg[g] <= wdata;
					if (index_reg == LDCD_IDX_BASE_LOW && uses_base(LDN))
						base_lo_reg[g] <= wdata;
					if (index_reg == LDCD_IDX_BASE2_HIGH && uses_base2(LDN))
						base2_hi_reg[g] <= wdata;
					if (index_reg == LDCD_IDX_BASE2_LOW && uses_base2(LDN))
						base2_lo_reg[g] <= wdata;
				end
			end

			always_ff @(posedge clk_sys)
			begin
				if (rst)
					irq_reg[g] <= irq_default(LDN);
				else if (sel && index_reg == LDCD_IDX_IRQ_PRI)
					irq_reg[g] <= wdata;
			end

			always_ff @(posedge clk_sys)
			begin
				if (rst)
					dma_reg[g] <= uses_dma(LDN) ? dma_default(LDN) : LDCD_RST_ZERO;
				else if (sel && index_reg == LDCD_IDX_DMA && uses_dma(LDN))
					dma_reg[g] <= wdata;
			end

			assign dec_bus.base[g]   = {base_hi_reg[g], base_lo_reg[g]};
			assign dec_bus.active[g] = act_reg[g];
		end
	endgenerate

	// Second interrupt select lives only in the keyboard controller bank
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			irq2_reg <= LDCD_RST_ZERO;
		else if (cfg_wr && ldn_reg == LDCD_LDN_KEYBOARD && index_reg == LDCD_IDX_IRQ_SEC)
			irq2_reg <= wdata;
	end

	// Read data: everything not implemented for the bank reads zero
	always_comb
	begin
		rdata_next = LDCD_RST_ZERO;
		if (index_reg == LDCD_IDX_LDN)
			rdata_next = {4'h0, ldn_reg};
		else if (!ldn_exists(ldn_reg))
			rdata_next = LDCD_RST_ZERO;
		else if (index_reg == LDCD_IDX_ACTIVATE)
			rdata_next = {7'h00, act_reg[ldn_reg]};
		else if (index_reg >= LDCD_IDX_RSV_LO && index_reg <= LDCD_IDX_RSV_HI)
			rdata_next = LDCD_RST_ZERO;
		else if (index_reg == LDCD_IDX_BASE_HIGH && uses_base(ldn_reg))
			rdata_next = base_hi_reg[ldn_reg];
		else if (index_reg == LDCD_IDX_BASE_LOW && uses_base(ldn_reg))
			rdata_next = base_lo_reg[ldn_reg];
		else if (index_reg == LDCD_IDX_BASE2_HIGH && uses_base2(ldn_reg))
			rdata_next = base2_hi_reg[ldn_reg];
		else if (index_reg == LDCD_IDX_BASE2_LOW && uses_base2(ldn_reg))
			rdata_next = base2_lo_reg[ldn_reg];
		else if (index_reg == LDCD_IDX_IRQ_PRI)
			rdata_next = irq_reg[ldn_reg];
		else if (index_reg == LDCD_IDX_IRQ_SEC && ldn_reg == LDCD_LDN_KEYBOARD)
			rdata_next = irq2_reg;
		else if (index_reg == LDCD_IDX_DMA && uses_dma(ldn_reg))
			rdata_next = dma_reg[ldn_reg];
		else
			rdata_next = LDCD_RST_ZERO;
	end

	// Reads outside the configuration state return zero; rdata holds until the next read
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			rdata_reg <= LDCD_RST_ZERO;
		else if (data_rd)
			rdata_reg <= cfg_ok ? rdata_next : LDCD_RST_ZERO;
	end

	// Address decode
	assign dec_bus.qual16 = qual16;
	assign dec_bus.addr   = io_addr;
	assign dec_bus.cycle  = io_cycle;

	ldcd_addr_decode u_dec (
		.d (dec_bus.dec)
	);

	// Claim flags are registered so every output leaves a flop
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			hit_reg <= '0;
			ecp_reg <= 1'b0;
			epp_reg <= 1'b0;
		end
		else
		begin
			hit_reg <= dec_bus.hit;
			ecp_reg <= dec_bus.ecp_hit;
			epp_reg <= dec_bus.epp_ok;
		end
	end

	// Base check runs every cycle, so a new base shows its verdict one clock after the write
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			valid_reg <= '0;
		else
			valid_reg <= dec_bus.base_ok;
	end

	// Interrupt polarity is fixed: edge high for every device
	logic edge_reg;
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			edge_reg <= LDCD_IRQ_EDGE_HIGH;
		else
			edge_reg <= LDCD_IRQ_EDGE_HIGH;
	end

	assign rdata         = rdata_reg;
	assign index         = index_reg;
	assign io_hit        = hit_reg;
	assign ecp_hit       = ecp_reg;
	assign epp_ok        = epp_reg;
	assign dev_on        = act_reg;
	assign base_valid    = valid_reg;
	assign irq_edge_high = edge_reg;
endmodule

// ===== sim/ldcd_bank_chk.sv
/*
 Concurrent checks on the configuration bank ports.
 Assumes it is bound to every ldcd_bank instance.
*/
module ldcd_bank_chk
	import ldcd_pkg::*;
#(
	parameter int NUM_DEV = LDCD_NUM_DEV
)
(
	// Clock and reset
	input wire logic        clk_sys,
	input wire logic        rst,
	// Configuration port
	input wire logic        cfg_mode,
	input wire logic        idx_wr,
	input wire logic        data_rd,
	input wire logic [7:0]  wdata,
	input wire logic [7:0]  rdata,
	input wire logic [7:0]  index,
	// Host I/O cycle
	input wire logic        qual16,
	input wire logic        io_cycle,
	input wire logic [15:0] io_addr,
	input wire logic [11:0] io_hit,
	input wire logic        ecp_hit,
	// Device state
	input wire logic [11:0] dev_on,
	input wire logic [11:0] base_valid,
	input wire logic        irq_edge_high
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	a_rsv_zero: assert property (data_rd && index inside {[8'h31:8'h5f]} |=> rdata == 8'h00)
		else $error("reserved index read not zero");
	a_rd_nocfg: assert property (data_rd && !cfg_mode |=> rdata == 8'h00)
		else $error("read outside config state not zero");
	a_idx_load: assert property (idx_wr && cfg_mode |=> index == $past(wdata))
		else $error("index not loaded");
	a_hit_cause: assert property (|io_hit |-> $past(io_cycle))
		else $error("hit without cycle");
	a_hit_on: assert property ((io_hit & ~$past(dev_on)) == 12'h000)
		else $error("hit on inactive device");
	a_hit_valid: assert property ((io_hit & ~base_valid) == 12'h000)
		else $error("hit with invalid base");
	a_qual_top: assert property (io_cycle && qual16 && io_addr[15:12] != 4'h0 |=> io_hit == 12'h000)
		else $error("qualified upper address hit");
	a_kbd_fixed: assert property (io_cycle && dev_on[7] && io_addr inside {16'h0060, 16'h0064} |=> io_hit[7])
		else $error("keyboard address missed");
	a_ecp_cause: assert property (ecp_hit |-> $past(dev_on[3]) && $past(io_cycle))
		else $error("extended hit without cause");
	a_edge_high: assert property (!$past(rst) |-> irq_edge_high)
		else $error("interrupt polarity not edge high");
	cover property (io_hit[3]);
	cover property (ecp_hit);
	cover property (io_hit[7]);
endmodule

bind ldcd_bank ldcd_bank_chk #(.NUM_DEV(NUM_DEV)) chk (.clk_sys(clk_sys), .rst(rst), .cfg_mode(cfg_mode),
	.idx_wr(idx_wr), .data_rd(data_rd), .wdata(wdata), .rdata(rdata), .index(index), .qual16(qual16),
	.io_cycle(io_cycle), .io_addr(io_addr), .io_hit(io_hit), .ecp_hit(ecp_hit), .dev_on(dev_on),
	.base_valid(base_valid), .irq_edge_high(irq_edge_high));

// ===== sim/ldcd_host.sv
/*
 Host side of the index/data configuration port.
 Assumes strobes are sampled on the rising edge of clk_sys.
*/
module ldcd_host
(
	// Clock
	input wire logic       clk_sys,
	// Configuration port
	input wire logic [7:0] rdata,
	output logic           cfg_mode,
	output logic           idx_wr,
	output logic           data_wr,
	output logic           data_rd,
	output logic [7:0]     wdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		cfg_mode = 1'b0;
		idx_wr = 1'b0;
		data_wr = 1'b0;
		data_rd = 1'b0;
		wdata = 8'h00;
	end
	task automatic mode(input logic b);
		@(posedge clk_sys);
		#1 cfg_mode = b;
	endtask
	task automatic pick(input logic [7:0] i);
		@(posedge clk_sys);
		#1 idx_wr = 1'b1;
		wdata = i;
		@(posedge clk_sys);
		#1 idx_wr = 1'b0;
		wdata = ~i;
	endtask
	task automatic put(input logic [7:0] v);
		@(posedge clk_sys);
		#1 data_wr = 1'b1;
		wdata = v;
		@(posedge clk_sys);
		#1 data_wr = 1'b0;
		wdata = ~v;
	endtask
	task automatic get(output logic [7:0] v);
		@(posedge clk_sys);
		#1 data_rd = 1'b1;
		@(posedge clk_sys);
		#1 data_rd = 1'b0;
		v = rdata;
	endtask
endmodule

// ===== sim/logical_device_config_decode_bench.sv
/*
 Self-checking bench for the configuration bank and I/O decode.
 Assumes the bank checker is bound by its own file.
*/
module logical_device_config_decode_bench import ldcd_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_sys, rst, cfg_mode, idx_wr, data_wr, data_rd, qual16, io_cycle;
	logic        ecp_hit, epp_ok, irq_edge_high;
	logic [7:0]  wdata, rdata, index;
	logic [11:0] pwr_set, pwr_clr, io_hit, dev_on, base_valid;
	logic [15:0] io_addr;
	int          miscompares, compares, cycles;
	ldcd_bank #(.NUM_DEV(LDCD_NUM_DEV)) dut (.clk_sys(clk_sys), .rst(rst), .cfg_mode(cfg_mode), .idx_wr(idx_wr),
		.data_wr(data_wr), .data_rd(data_rd), .wdata(wdata), .rdata(rdata), .index(index), .pwr_set(pwr_set),
		.pwr_clr(pwr_clr), .qual16(qual16), .io_cycle(io_cycle), .io_addr(io_addr), .io_hit(io_hit),
		.ecp_hit(ecp_hit), .epp_ok(epp_ok), .dev_on(dev_on), .base_valid(base_valid), .irq_edge_high(irq_edge_high));
	ldcd_host host (.clk_sys(clk_sys), .rdata(rdata), .cfg_mode(cfg_mode), .idx_wr(idx_wr), .data_wr(data_wr),
		.data_rd(data_rd), .wdata(wdata));
	initial
	begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	task automatic final_report();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			miscompares++;
			final_report();
		end
	end
	task automatic ck(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp)
		begin
			miscompares++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wreg(input logic [7:0] ldn, input logic [7:0] i, input logic [7:0] v);
		host.pick(LDCD_IDX_LDN);
		host.put(ldn);
		host.pick(i);
		host.put(v);
	endtask
	task automatic rreg(input logic [7:0] ldn, input logic [7:0] i, input logic [7:0] exp);
		logic [7:0] v;
		host.pick(LDCD_IDX_LDN);
		host.put(ldn);
		host.pick(i);
		host.get(v);
		ck({8'h00, v}, {8'h00, exp});
	endtask
	task automatic base(input logic [7:0] ldn, input logic [15:0] b);
		wreg(ldn, LDCD_IDX_BASE_HIGH, b[15:8]);
		wreg(ldn, LDCD_IDX_BASE_LOW, b[7:0]);
		repeat (2) @(posedge clk_sys);
		#1;
	endtask
	task automatic probe(input logic [15:0] a);
		@(posedge clk_sys);
		#1 io_cycle = 1'b1;
		io_addr = a;
		@(posedge clk_sys);
		#1 io_cycle = 1'b0;
	endtask
	task automatic t_defaults();
		ck({4'h0, base_valid}, 16'h0480);
		rreg(8'h00, 8'h70, 8'h06);
		rreg(8'h04, 8'h70, 8'h00);
		rreg(8'h00, 8'h74, 8'h02);
		rreg(8'h03, 8'h74, 8'h04);
		rreg(8'h07, 8'h72, 8'h00);
		rreg(8'h09, 8'h60, 8'h00);
		ck({8'h00, index}, 16'h0060);
		ck({15'h0000, irq_edge_high}, 16'h0001);
	endtask
	task automatic t_reserved();
		logic [7:0] v;
		logic [7:0] rsv [19] = '{8'h31, 8'h37, 8'h38, 8'h3f, 8'h40, 8'h5f, 8'h62, 8'h63, 8'h64, 8'h6f, 8'h71,
			8'h72, 8'h73, 8'h74, 8'h75, 8'h76, 8'ha8, 8'ha9, 8'hdf};
		foreach (rsv[k])
		begin
			wreg(8'h04, rsv[k], 8'hff);
			rreg(8'h04, rsv[k], 8'h00);
		end
		wreg(8'h07, 8'h72, 8'h5a);
		rreg(8'h07, 8'h72, 8'h5a);
		wreg(8'h03, 8'h74, 8'h01);
		rreg(8'h03, 8'h74, 8'h01);
		wreg(8'h05, 8'h61, 8'ha8);
		rreg(8'h05, 8'h61, 8'ha8);
		wreg(8'h05, 8'h70, 8'h0b);
		rreg(8'h05, 8'h70, 8'h0b);
		host.mode(1'b0);
		host.put(8'h0c);
		host.get(v);
		ck({8'h00, v}, 16'h0000);
		host.mode(1'b1);
		host.get(v);
		ck({8'h00, v}, 16'h000b);
	endtask
	task automatic t_valid();
		logic [7:0]  dl [12] = '{8'h04, 8'h04, 8'h04, 8'h00, 8'h03, 8'h03, 8'h03, 8'h09, 8'h0a, 8'h0a, 8'h0b, 8'h0b};
		logic [15:0] bl [12] = '{16'h00f8, 16'h0ffc, 16'h0ff8, 16'h0100, 16'h0ffc, 16'h037e, 16'h037c, 16'h0101,
			16'h0f80, 16'h0f00, 16'h0103, 16'h0102};
		logic        vl [12] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
		foreach (dl[k])
		begin
			base(dl[k], bl[k]);
			ck({15'h0000, base_valid[dl[k]]}, {15'h0000, vl[k]});
		end
	endtask
	task automatic t_decode();
		wreg(8'h03, 8'h30, 8'h01);
		probe(16'h037f);
		ck({4'h0, io_hit}, 16'h0008);
		ck({15'h0000, epp_ok}, 16'h0000);
		probe(16'h0380);
		ck({4'h0, io_hit}, 16'h0000);
		base(8'h03, 16'h0378);
		probe(16'h037f);
		ck({4'h0, io_hit}, 16'h0008);
		ck({15'h0000, epp_ok}, 16'h0001);
		probe(16'h077a);
		ck({15'h0000, ecp_hit}, 16'h0001);
		wreg(8'h03, 8'h30, 8'h00);
		probe(16'h0378);
		ck({4'h0, io_hit}, 16'h0000);
		wreg(8'h04, 8'h30, 8'h01);
		probe(16'h0fff);
		ck({4'h0, io_hit}, 16'h0010);
		probe(16'h1ff8);
		ck({4'h0, io_hit}, 16'h0010);
		qual16 = 1'b1;
		probe(16'h1ff8);
		ck({4'h0, io_hit}, 16'h0000);
		wreg(8'h07, 8'h30, 8'h01);
		probe(16'h0064);
		ck({4'h0, io_hit}, 16'h0080);
		probe(16'h0062);
		ck({4'h0, io_hit}, 16'h0000);
		wreg(8'h09, 8'h30, 8'h01);
		probe(16'h0101);
		ck({4'h0, io_hit}, 16'h0200);
		wreg(8'h0a, 8'h30, 8'h01);
		probe(16'h0f5f);
		ck({4'h0, io_hit}, 16'h0400);
		wreg(8'h0b, 8'h30, 8'h01);
		probe(16'h0103);
		ck({4'h0, io_hit}, 16'h0800);
		wreg(8'h0b, 8'h30, 8'h00);
	endtask
	task automatic t_power();
		pwr_set = 12'h800;
		@(posedge clk_sys);
		#1 pwr_set = 12'h000;
		ck({4'h0, dev_on}, 16'h0e90);
		rreg(8'h0b, 8'h30, 8'h01);
		pwr_clr = 12'h800;
		@(posedge clk_sys);
		#1 pwr_clr = 12'h000;
		ck({4'h0, dev_on}, 16'h0690);
		rreg(8'h0b, 8'h30, 8'h00);
	endtask
	task automatic t_reset();
		@(posedge clk_sys);
		#1 rst = 1'b1;
		repeat (2) @(posedge clk_sys);
		#1 rst = 1'b0;
		ck({4'h0, dev_on}, 16'h0000);
		rreg(8'h03, 8'h74, 8'h04);
		rreg(8'h05, 8'h70, 8'h00);
		rreg(8'h07, 8'h72, 8'h00);
		ck({4'h0, base_valid}, 16'h0480);
	endtask
	initial
	begin
		rst = 1'b1;
		{pwr_set, pwr_clr, qual16, io_cycle, io_addr} = '0;
		{miscompares, compares, cycles} = '0;
		repeat (6) @(posedge clk_sys);
		#1 rst = 1'b0;
		host.mode(1'b1);
		t_defaults();
		t_reserved();
		t_valid();
		t_decode();
		t_power();
		t_reset();
		final_report();
	end
endmodule
